// [rtl/ssp_port.sv]
// Function
// - Master or slave mode selectable
// - Word length programmable four to sixteen
// - Separate eight-deep sixteen-bit transmit, receive FIFOs
// - Serialise transmit words, deserialise receive bits
// - Master clock from prescaler then divider
// - Rates up to five MHz reachable
// - Two control registers choose mode, format
// - Registers reached over APB bus
// - Four maskable interrupts provided
// - Overrun flagged when receive FIFO full
// - Timeout flagged while receive data waits
// - Combined interrupt ORs unmasked sources
// - DMA request signals for both FIFOs
// - SSI format frame pulse active high
// - SPI, command formats select active low
// - Transmit pad output always enabled
// - Clock pad output master, input slave
// - Link timing from reference clock
// - Prescaler even divisors two to 254
// - Divider one to 256 after prescaler
// - Disabled after reset until enabled
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ssp_port #(
   parameter int unsigned RX_TIMEOUT_CYCLES = ssp_pkg::RX_TIMEOUT_DEF // Idle limit
) (
   input  wire logic                         clk,                  // Core and reference clock
   input  wire logic                         rst,                  // Synchronous reset
   input  wire logic                         psel,                 // APB select
   input  wire logic                         penable,              // APB access phase
   input  wire logic                         pwrite,               // APB write
   input  wire logic [ssp_pkg::APB_AW-1:0]   paddr,                // APB byte address
   input  wire logic [ssp_pkg::APB_DW-1:0]   pwdata,               // APB write data
   output logic      [ssp_pkg::APB_DW-1:0]   prdata,               // APB read data
   output logic                              pready,               // APB ready
   output logic                              pslverr,              // Unmapped address
   input  wire logic                         serial_in_line,       // Receive data pin
   output logic                              serial_out_line,      // Transmit data pin
   output logic                              serial_out_oe,        // Transmit pad enable
   input  wire logic                         slave_bit_clock_in,   // Clock pad input
   output logic                              master_bit_clock_out, // Clock pad output
   output logic                              bit_clock_oe,         // Clock pad enable
   input  wire logic                         slave_select_in_n,    // Select from master
   output logic                              frame_select_out,     // Frame or select out
   output logic                              frame_select_oe,      // Frame pad enable
   output logic                              tx_service_irq,       // Transmit FIFO low
   output logic                              rx_service_irq,       // Receive FIFO high
   output logic                              rx_overrun_irq,       // Receive overrun
   output logic                              rx_timeout_irq,       // Receive timeout
   output logic                              combined_irq,         // Any unmasked source
   output logic                              tx_dma_req,           // Transmit DMA request
   output logic                              rx_dma_req            // Receive DMA request
);
   import ssp_pkg::*;

   // Address decode used only by the error answer; the read mux has its own case
   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == OFS_CTRL0) || (a == OFS_CTRL1) || (a == OFS_DATA) ||
                  (a == OFS_STAT)  || (a == OFS_PRESC) || (a == OFS_MASK) ||
                  (a == OFS_RAW)   || (a == OFS_MIS)   || (a == OFS_CLR)  ||
                  (a == OFS_DMA);
   endfunction

   // Mask of valid low bits for a word size
   function automatic logic [15:0] size_mask(input logic [3:0] sz);
      size_mask = 16'hFFFF >> (4'hF - sz);
   endfunction

   // Register state
   logic [15:0] ctrl0_q, ctrl0_d;                  // control_word_zero
   logic [15:0] ctrl1_q, ctrl1_d;                  // control_word_one
   logic [7:0]  presc_q, presc_d;                  // prescale_divisor
   logic [3:0]  mask_q, mask_d;                    // Interrupt mask
   logic [1:0]  dma_q, dma_d;                      // DMA enables
   logic        ovr_q, ovr_d;                      // Sticky overrun
   logic        tmo_q, tmo_d;                      // Sticky timeout
   logic [31:0] rdata_q, rdata_d;                  // Read data holding
   logic [15:0] tout_q, tout_d;                    // Receive idle counter

   // FIFO state
   logic [15:0]      tx_mem [FIFO_DEPTH];          // Transmit storage
   logic [15:0]      rx_mem [FIFO_DEPTH];          // Receive storage
   logic [PTR_W-1:0] tx_wr_q, tx_wr_d, tx_rd_q, tx_rd_d; // Transmit pointers
   logic [PTR_W-1:0] rx_wr_q, rx_wr_d, rx_rd_q, rx_rd_d; // Receive pointers

   // Engine state
   ssp_state_e  st_q, st_d;                        // Engine state
   logic [15:0] sh_q, sh_d;                        // Transmit shifter
   logic [15:0] rs_q, rs_d;                        // Receive shifter
   logic [3:0]  bit_q, bit_d;                      // Bits left minus one
   logic        phase_q, phase_d;                  // Master clock phase
   logic [6:0]  pre_q, pre_d;                      // Prescaler count
   logic [7:0]  div_q, div_d;                      // Rate divider count
   logic        sprev_q, sprev_d;                  // Last slave clock level

   // Decoded controls
   logic        enable, slave, cpol;               // Mode bits
   logic [3:0]  size;                              // Word size minus one
   logic [1:0]  fmt;                               // Frame format
   logic [6:0]  half;                              // Prescaler half period
   logic [3:0]  tx_lvl, rx_lvl;                    // FIFO fill levels
   logic        tx_empty, tx_full, rx_empty, rx_full; // FIFO flags
   logic        wr_acc, rd_setup, rd_acc;          // Bus strobes
   logic        tx_push, tx_pop, rx_push, rx_pop;  // FIFO moves
   logic        tick, lead, trail, slv_lvl;        // Bit timing events
   logic [3:0]  raw;                               // Raw interrupt vector

   // Control decode and FIFO flags
   always_comb begin
      enable   = ctrl1_q[C1_EN_BIT];
      slave    = ctrl1_q[C1_SLV_BIT];
      cpol     = ctrl0_q[C0_CPOL_BIT];
      fmt      = ctrl0_q[C0_FMT_LSB +: 2];
      // Sizes below four bits are raised to four
      size     = (ctrl0_q[C0_SIZE_LSB +: 4] < MIN_SIZE) ? MIN_SIZE
                 : ctrl0_q[C0_SIZE_LSB +: 4];
      // Least significant divisor bit ignored, zero treated as two
      half     = (presc_q[7:1] == 7'h00) ? 7'h01 : presc_q[7:1];
      tx_lvl   = tx_wr_q - tx_rd_q;
      rx_lvl   = rx_wr_q - rx_rd_q;
      tx_empty = (tx_lvl == 4'h0);
      tx_full  = (tx_lvl == FIFO_FULL);
      rx_empty = (rx_lvl == 4'h0);
      rx_full  = (rx_lvl == FIFO_FULL);
      wr_acc   = psel & penable & pwrite;
      rd_setup = psel & ~penable & ~pwrite;
      rd_acc   = psel & penable & ~pwrite;
      tx_push  = wr_acc & (paddr == OFS_DATA) & ~tx_full;
      rx_pop   = rd_acc & (paddr == OFS_DATA) & ~rx_empty;
      tx_pop   = (st_q == ST_IDLE) & (st_d == ST_SHIFT) & ~tx_empty;
      rx_push  = (st_q == ST_DONE) & ~rx_full;
      raw      = {tmo_q, ovr_q, (rx_lvl >= RX_SRV_LEVEL),
                  (tx_lvl <= TX_SRV_LEVEL)};
   end

   // Bit timing: master ticks from the counters, slave edges from the pad
   always_comb begin
      tick    = (pre_q == 7'h00) && (div_q == 8'h00);
      slv_lvl = slave_bit_clock_in ^ cpol;
      if (slave) begin
         // External clock sampled directly, kept under a twelfth of clk
         lead  = slv_lvl & ~sprev_q & ~slave_select_in_n;
         trail = ~slv_lvl & sprev_q & ~slave_select_in_n;
      end else begin
         lead  = tick & ~phase_q;
         trail = tick & phase_q;
      end
   end

   // Serial engine next state
   always_comb begin
      st_d    = st_q;
      sh_d    = sh_q;
      rs_d    = rs_q;
      bit_d   = bit_q;
      phase_d = phase_q;
      pre_d   = pre_q;
      div_d   = div_q;
      sprev_d = slv_lvl;
      unique case (st_q)
         ST_IDLE: begin
            phase_d = 1'b0;
            pre_d   = half - 7'h01;
            div_d   = ctrl0_q[C0_DIV_LSB +: 8];
            bit_d   = size;
            // Master starts on queued data, slave on select
            if (enable && ((!slave && !tx_empty) || (slave && !slave_select_in_n))) begin
               st_d = ST_SHIFT;
               // Left align so the top bit leaves first
               sh_d = tx_empty ? 16'h0000 : (tx_mem[tx_rd_q[2:0]] << (4'hF - size));
               rs_d = 16'h0000;
            end
         end
         ST_SHIFT: begin
            // Prescaler then divider, reloading on each tick
            if (pre_q != 7'h00) begin
               pre_d = pre_q - 7'h01;
            end else begin
               pre_d = half - 7'h01;
               div_d = (div_q != 8'h00) ? div_q - 8'h01
                       : ctrl0_q[C0_DIV_LSB +: 8];
            end
            if (!slave && tick) begin
               phase_d = ~phase_q;
            end
            if (lead) begin
               rs_d = {rs_q[14:0], serial_in_line};
            end
            if (trail) begin
               sh_d = {sh_q[14:0], 1'b0};
               if (bit_q == 4'h0) begin
                  st_d = ST_DONE;
               end else begin
                  bit_d = bit_q - 4'h1;
               end
            end
            // Disable or lost select abandons the word
            if (!enable || (slave && slave_select_in_n)) begin
               st_d = ST_IDLE;
            end
         end
         ST_DONE: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // Serial engine registers
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q    <= ST_IDLE;
         sh_q    <= 16'h0000;
         rs_q    <= 16'h0000;
         bit_q   <= 4'h0;
         phase_q <= 1'b0;
         pre_q   <= 7'h00;
         div_q   <= 8'h00;
         sprev_q <= 1'b0;
      end else begin
         st_q    <= st_d;
         sh_q    <= sh_d;
         rs_q    <= rs_d;
         bit_q   <= bit_d;
         phase_q <= phase_d;
         pre_q   <= pre_d;
         div_q   <= div_d;
         sprev_q <= sprev_d;
      end
   end

   // FIFO pointer next values
   always_comb begin
      tx_wr_d = tx_wr_q + {3'h0, tx_push};
      tx_rd_d = tx_rd_q + {3'h0, tx_pop};
      rx_wr_d = rx_wr_q + {3'h0, rx_push};
      rx_rd_d = rx_rd_q + {3'h0, rx_pop};
   end

   // FIFO storage and pointers
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_wr_q <= '0;
         tx_rd_q <= '0;
         rx_wr_q <= '0;
         rx_rd_q <= '0;
      end else begin
         tx_wr_q <= tx_wr_d;
         tx_rd_q <= tx_rd_d;
         rx_wr_q <= rx_wr_d;
         rx_rd_q <= rx_rd_d;
      end
      if (tx_push) begin
         tx_mem[tx_wr_q[2:0]] <= pwdata[15:0];
      end
      if (rx_push) begin
         rx_mem[rx_wr_q[2:0]] <= rs_q & size_mask(size);
      end
   end

   // Register file next values
   always_comb begin
      ctrl0_d = ctrl0_q;
      ctrl1_d = ctrl1_q;
      presc_d = presc_q;
      mask_d  = mask_q;
      dma_d   = dma_q;
      ovr_d   = ovr_q;
      tmo_d   = tmo_q;
      rdata_d = rdata_q;
      // Writes take effect in the access phase
      if (wr_acc) begin
         unique case (paddr)
            OFS_CTRL0: ctrl0_d = pwdata[15:0];
            OFS_CTRL1: ctrl1_d = pwdata[15:0];
            OFS_PRESC: presc_d = {pwdata[7:1], 1'b0};
            OFS_MASK:  mask_d  = pwdata[3:0];
            OFS_DMA:   dma_d   = pwdata[1:0];
            OFS_CLR: begin
               if (pwdata[IRQ_OR]) begin
                  ovr_d = 1'b0;
               end
               if (pwdata[IRQ_TO]) begin
                  tmo_d = 1'b0;
               end
            end
            default: ;                             // Data push elsewhere, read only or unmapped
         endcase
      end
      // Hardware set wins over a clear in the same cycle
      if ((st_q == ST_DONE) && rx_full) begin
         ovr_d = 1'b1;
      end
      // Idle receive data with no traffic counts toward timeout
      if (rx_empty || rx_push || rx_pop) begin
         tout_d = 16'h0000;
      end else if (tout_q == 16'(RX_TIMEOUT_CYCLES - 1)) begin
         tout_d = tout_q;
         tmo_d  = 1'b1;
      end else begin
         tout_d = tout_q + 16'h0001;
      end
      // Read data captured in the setup phase
      if (rd_setup) begin
         unique case (paddr)
            OFS_CTRL0: rdata_d = {16'h0000, ctrl0_q};
            OFS_CTRL1: rdata_d = {16'h0000, ctrl1_q};
            OFS_DATA:  rdata_d = {16'h0000, rx_mem[rx_rd_q[2:0]]};
            OFS_STAT:  rdata_d = {27'h0000000, (st_q != ST_IDLE), rx_full,
                                  ~rx_empty, ~tx_full, tx_empty};
            OFS_PRESC: rdata_d = {24'h000000, presc_q};
            OFS_MASK:  rdata_d = {28'h0000000, mask_q};
            OFS_RAW:   rdata_d = {28'h0000000, raw};
            OFS_MIS:   rdata_d = {28'h0000000, raw & mask_q};
            OFS_DMA:   rdata_d = {30'h00000000, dma_q};
            default:   rdata_d = 32'h00000000;     // Unmapped and clear reg
         endcase
      end
   end

   // Register file
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl0_q <= CTRL0_RST;
         ctrl1_q <= CTRL1_RST;
         presc_q <= PRESC_RST;
         mask_q  <= MASK_RST;
         dma_q   <= DMA_RST;
         ovr_q   <= 1'b0;
         tmo_q   <= 1'b0;
         rdata_q <= 32'h00000000;
         tout_q  <= 16'h0000;
      end else begin
         ctrl0_q <= ctrl0_d;
         ctrl1_q <= ctrl1_d;
         presc_q <= presc_d;
         mask_q  <= mask_d;
         dma_q   <= dma_d;
         ovr_q   <= ovr_d;
         tmo_q   <= tmo_d;
         rdata_q <= rdata_d;
         tout_q  <= tout_d;
      end
   end

   // Bus answer: always ready, error on unmapped
   assign prdata  = rdata_q;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~is_mapped(paddr);

   // Pads
   assign serial_out_line      = sh_q[15];
   assign serial_out_oe        = 1'b1;
   assign master_bit_clock_out = phase_q ^ cpol;
   assign bit_clock_oe         = ~slave;
   assign frame_select_oe      = ~slave;
   // SSI pulses high in the first bit, others select low for the word
   assign frame_select_out = (fmt == FMT_SSI) ?
                             ((st_q == ST_SHIFT) && (bit_q == size))
                             : (st_q != ST_SHIFT);

   // Interrupts and DMA
   assign tx_service_irq = raw[IRQ_TX] & mask_q[IRQ_TX];
   assign rx_service_irq = raw[IRQ_RX] & mask_q[IRQ_RX];
   assign rx_overrun_irq = raw[IRQ_OR] & mask_q[IRQ_OR];
   assign rx_timeout_irq = raw[IRQ_TO] & mask_q[IRQ_TO];
   assign combined_irq   = |(raw & mask_q);
   assign tx_dma_req     = dma_q[0] & ~tx_full;
   assign rx_dma_req     = dma_q[1] & ~rx_empty;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_ovr_set;
      (st_q == ST_DONE) && rx_full |=> ovr_q && rx_overrun_irq == mask_q[IRQ_OR];
   endproperty
   a_ovr_set: assert property (p_ovr_set)
      else $error("overrun not flagged");

   property p_ovr_keep;
      (st_q == ST_DONE) && rx_full && !rx_pop |=> rx_wr_q == $past(rx_wr_q);
   endproperty
   a_ovr_keep: assert property (p_ovr_keep)
      else $error("overrun word stored");

   property p_disabled;
      !enable |=> st_q == ST_IDLE;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("engine runs while disabled");

   property p_tx_pad;
      serial_out_oe;
   endproperty
   a_tx_pad: assert property (p_tx_pad)
      else $error("transmit pad released");

   property p_spi_sel;
      !slave && fmt == FMT_SPI && st_q == ST_SHIFT |-> !frame_select_out;
   endproperty
   a_spi_sel: assert property (p_spi_sel)
      else $error("select not low in frame");

   property p_ssi_idle;
      fmt == FMT_SSI && st_q == ST_IDLE |-> !frame_select_out;
   endproperty
   a_ssi_idle: assert property (p_ssi_idle)
      else $error("frame pulse while idle");

   property p_levels;
      tx_lvl <= FIFO_FULL && rx_lvl <= FIFO_FULL;
   endproperty
   a_levels: assert property (p_levels)
      else $error("fifo level beyond depth");

   property p_timeout;
      tout_q == 16'(RX_TIMEOUT_CYCLES - 1) && !rx_empty && !rx_push && !rx_pop |=> tmo_q;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("timeout not raised");

   property p_master_clk;
      !slave && st_q == ST_SHIFT && tick && st_d == ST_SHIFT |=> phase_q != $past(phase_q);
   endproperty
   a_master_clk: assert property (p_master_clk)
      else $error("bit clock did not toggle");

   property p_comb;
      combined_irq == (tx_service_irq | rx_service_irq | rx_overrun_irq | rx_timeout_irq);
   endproperty
   a_comb: assert property (p_comb)
      else $error("combined interrupt mismatch");
endmodule // ssp_port
`default_nettype wire

// [rtl/ssp_pkg.sv]
// Shared constants for the synchronous serial port
package ssp_pkg;
   // Bus and data widths
   localparam int unsigned APB_AW     = 12;           // Byte address width
   localparam int unsigned APB_DW     = 32;           // Bus data width
   localparam int unsigned WORD_W     = 16;           // Widest serial word
   localparam int unsigned FIFO_DEPTH = 8;            // Entries per FIFO
   localparam int unsigned PTR_W      = 4;            // Pointer with wrap bit

   // Register byte offsets
   localparam logic [11:0] OFS_CTRL0 = 12'h000;       // control_word_zero
   localparam logic [11:0] OFS_CTRL1 = 12'h004;       // control_word_one
   localparam logic [11:0] OFS_DATA  = 12'h008;       // FIFO data port
   localparam logic [11:0] OFS_STAT  = 12'h00C;       // FIFO and engine status
   localparam logic [11:0] OFS_PRESC = 12'h010;       // prescale_divisor
   localparam logic [11:0] OFS_MASK  = 12'h014;       // Interrupt mask
   localparam logic [11:0] OFS_RAW   = 12'h018;       // Raw interrupt state
   localparam logic [11:0] OFS_MIS   = 12'h01C;       // Masked interrupt state
   localparam logic [11:0] OFS_CLR   = 12'h020;       // Write one to clear
   localparam logic [11:0] OFS_DMA   = 12'h024;       // DMA request enables

   // control_word_zero fields
   localparam int unsigned C0_SIZE_LSB = 0;           // Word size minus one, 4 bits
   localparam int unsigned C0_FMT_LSB  = 4;           // Frame format, 2 bits
   localparam int unsigned C0_CPOL_BIT = 6;           // Idle clock level
   localparam int unsigned C0_DIV_LSB  = 8;           // bit_rate_divider_field, 8 bits
   // control_word_one fields
   localparam int unsigned C1_EN_BIT   = 1;           // Port enable
   localparam int unsigned C1_SLV_BIT  = 2;           // Slave mode select
   // Status fields
   localparam int unsigned ST_TFE = 0;                // Transmit FIFO empty
   localparam int unsigned ST_TNF = 1;                // Transmit FIFO not full
   localparam int unsigned ST_RNE = 2;                // Receive FIFO not empty
   localparam int unsigned ST_RFF = 3;                // Receive FIFO full
   localparam int unsigned ST_BSY = 4;                // Engine busy
   // Interrupt bit positions
   localparam int unsigned IRQ_TX = 0;                // Transmit service
   localparam int unsigned IRQ_RX = 1;                // Receive service
   localparam int unsigned IRQ_OR = 2;                // Receive overrun
   localparam int unsigned IRQ_TO = 3;                // Receive timeout

   // Reset values
   localparam logic [15:0] CTRL0_RST = 16'h0000;      // 4-bit SPI frames
   localparam logic [15:0] CTRL1_RST = 16'h0000;      // Disabled master
   localparam logic [7:0]  PRESC_RST = 8'h00;         // Treated as two
   localparam logic [3:0]  MASK_RST  = 4'h0;          // All masked
   localparam logic [1:0]  DMA_RST   = 2'h0;          // No DMA requests

   // Levels and limits
   localparam logic [3:0]  MIN_SIZE     = 4'h3;       // Four bit words
   localparam logic [3:0]  TX_SRV_LEVEL = 4'h4;       // Half full or less
   localparam logic [3:0]  RX_SRV_LEVEL = 4'h4;       // Half full or more
   localparam logic [3:0]  FIFO_FULL    = 4'h8;       // Level when full
   localparam int unsigned CLK_HZ       = 10_000_000; // Core clock rate
   localparam int unsigned RX_TIMEOUT_DEF = 64;       // Idle cycles before timeout

   // Frame formats
   typedef enum logic [1:0] {
      FMT_SPI = 2'h0,                                 // Select low during word
      FMT_SSI = 2'h1,                                 // High pulse in first bit
      FMT_CMD = 2'h2                                  // Full duplex as SPI, select low
   } ssp_fmt_e;

   // Serial engine states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,                              // Waiting for work
      ST_SHIFT = 3'b010,                              // Moving bits
      ST_DONE  = 3'b100                               // Storing received word
   } ssp_state_e;
endpackage

// [tb/ssp_peer.sv]
`timescale 1ns/1ps
`default_nettype none
// Eight-bit slave that echoes the previous frame back
module ssp_peer #(
   parameter logic [7:0] FIRST = 8'h3C  // Word returned in the first frame
) (
   input  wire logic sclk,  // Bit clock from port
   input  wire logic sel_n, // Active low select
   input  wire logic mosi,  // Data from port
   output logic      miso   // Data to port
);
   logic [7:0] tx_sr = FIRST; // Outgoing shifter
   logic [7:0] rx_sr = FIRST; // Incoming shifter
   initial miso = 1'b0;
   // Load echo word when selected
   always @(negedge sel_n) begin
      tx_sr = rx_sr;
      miso = rx_sr[7];
   end
   // Sample on leading edge
   always @(posedge sclk) if (!sel_n) rx_sr = {rx_sr[6:0], mosi};
   // Shift on trailing edge
   always @(negedge sclk) if (!sel_n) begin
      tx_sr = tx_sr << 1;
      miso = tx_sr[7];
   end
   // Released line shows the inverse of its last value
   always @(posedge sel_n) miso = ~miso;
endmodule // ssp_peer
`default_nettype wire

// [tb/synchronous_serial_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
module synchronous_serial_port_test;
   import ssp_pkg::*;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0; // Bus controls
   logic [11:0] paddr = 0; // Byte address
   logic [31:0] pwdata = 0, prdata, rdata; // Data paths
   logic pready, pslverr, miso, mosi, oe, sck, ck_oe, fso, fs_oe; // Pins
   logic txi, rxi, ori, toi, cmb, txd, rxd; // Requests
   logic [32:0] q[$]; // Expected reads, flag and value
   logic [7:0] tx[8], w9; // Random words sent
   logic [32:0] n; // Oldest note
   logic s_clk = 0, s_ssn = 1; // Far-side master clock and select
   int bad_count = 0, check_count = 0;
   always #50 clk = ~clk;
   ssp_port #(.RX_TIMEOUT_CYCLES(8)) i_dut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serial_in_line(miso), .serial_out_line(mosi),
      .serial_out_oe(oe), .slave_bit_clock_in(s_clk), .master_bit_clock_out(sck),
      .bit_clock_oe(ck_oe), .slave_select_in_n(s_ssn), .frame_select_out(fso),
      .frame_select_oe(fs_oe), .tx_service_irq(txi), .rx_service_irq(rxi),
      .rx_overrun_irq(ori), .rx_timeout_irq(toi), .combined_irq(cmb),
      .tx_dma_req(txd), .rx_dma_req(rxd));
   // Peer follows the port's pins in master mode, the bench's in slave mode
   ssp_peer i_peer (.sclk(ck_oe ? sck : s_clk), .sel_n(ck_oe ? fso : s_ssn), .mosi(mosi),
      .miso(miso));
   // Compare one value
   task automatic chk(input logic [31:0] a, input logic [31:0] b);
      check_count++;
      if (a !== b) begin
         bad_count++;
         $display("Error t=%0t seen %h exp %h", $time, a, b);
      end
   endtask
   // One APB transfer
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic c, input logic [31:0] e);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) q.push_back({c, e});
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      if (!w) rdata = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   // Wait until engine idle and transmit empty
   task automatic idle();
      for (int i = 0; i < 200; i++) begin
         xfer(0, OFS_STAT, 0, 0, 0);
         if (rdata[ST_BSY] === 1'b0 && rdata[ST_TFE] === 1'b1) return;
      end
      bad_count++;
   endtask
   // One slave frame of eight bits, bit clock a sixteenth of clk
   task automatic sframe();
      @(posedge clk);
      s_ssn <= 0;
      repeat (8) begin
         repeat (8) @(posedge clk);
         s_clk <= 1;
         repeat (8) @(posedge clk);
         s_clk <= 0;
      end
      repeat (8) @(posedge clk);
      s_ssn <= 1;
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Read monitor takes the oldest note
   always @(posedge clk) if (psel && penable && pready === 1'b1) begin
      chk(pslverr, paddr > OFS_DMA);
      if (!pwrite) begin
         n = q.pop_front();
         if (n[32]) chk(prdata, n[31:0]);
      end
   end
   // Hang guard
   initial begin
      #2_000_000;
      bad_count++;
      test_done();
   end
   // Main sequence
   initial begin
      void'($urandom(32'h771fccfe));
      repeat (10) @(posedge clk);
      rst <= 0;
      xfer(0, OFS_CTRL1, 0, 1, 0);
      xfer(0, 12'h100, 0, 1, 0);
      xfer(1, OFS_CTRL0, 32'h0007, 0, 0);
      xfer(1, OFS_PRESC, 32'h0003, 0, 0);
      xfer(1, OFS_DMA, 32'h0003, 0, 0);
      for (int i = 0; i < 8; i++) begin
         tx[i] = $urandom & 8'hFF;
         xfer(1, OFS_DATA, {24'h0, tx[i]}, 0, 0);
      end
      @(negedge clk);
      chk(txd, 0);
      xfer(1, OFS_CTRL1, 32'h0002, 0, 0);
      idle();
      w9 = $urandom;
      xfer(1, OFS_DATA, {24'h0, w9}, 0, 0);
      idle();
      @(negedge clk);
      chk({oe, ck_oe, fs_oe, fso}, 4'hF);
      repeat (20) @(posedge clk);
      xfer(0, OFS_RAW, 0, 1, 32'hF);
      xfer(1, OFS_MASK, 32'hF, 0, 0);
      @(negedge clk);
      chk({cmb, ori, rxd}, 3'h7);
      xfer(1, OFS_CLR, 32'h4, 0, 0);
      @(negedge clk);
      chk(ori, 0);
      for (int k = 0; k < 8; k++)
         xfer(0, OFS_DATA, 0, 1, k ? tx[k-1] : 8'h3C);
      // Slave mode: the bench clocks two frames, the peer echoes
      xfer(1, OFS_CTRL1, 32'h0006, 0, 0);
      tx[0] = $urandom;
      xfer(1, OFS_DATA, {24'h0, tx[0]}, 0, 0);
      sframe();
      sframe();
      xfer(0, OFS_DATA, 0, 1, w9);
      xfer(0, OFS_DATA, 0, 1, tx[0]);
      xfer(1, OFS_CTRL0, 32'h0017, 0, 0);
      @(negedge clk);
      chk({ck_oe, fso}, 2'h0);
      test_done();
   end
endmodule // synchronous_serial_port_test
`default_nettype wire
